/* hw/dtfc_core.sv */
// Task-file command handling for power query, device reset, microcode and diagnostics
// Behaviour
// - On abort clear busy and data request, set ready, fault if faulted, error flag.
// - Power mode query leaves power state and standby timer untouched.
// - Query answers in count register: 00h standby, 80h idle, FFh active.
// - Power query and microcode download are aborted unless ready at command write.
// - Reset command 08h acts only on the addressed device.
// - Reset is accepted while busy, data request, not ready or asleep.
// - A supported reset never completes with an error indication.
// - Unsupported reset aborts when idle; busy case is left undefined.
// - After reset, error holds diagnostic code, registers hold signature, head bits zero.
// - Download length is sector number high byte and count low byte.
// - Zero count means no data phase; else whole 512-byte sectors.
// - Subcommand 01h applies code temporarily, 07h applies and keeps it.
// - Download aborts when unsupported, bad subcommand or data rejected.
// - Download may abort when the action cannot be completed.
// - Good download clears busy, fault, data request and error, sets ready.
// - Diagnostics command 90h ignores the device select bit.
// - Every present device runs diagnostics, selected or not.
// - Device 0 accepts diagnostics whatever the ready state.
`timescale 1ns/1ps
`include "dtfc_defs.svh"
module dtfc_core (
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire dtfc_pkg::dtfc_wb_req_s i_wb,
	output logic o_wb_ack,
	output logic [31:0] o_wb_dat
);
	import dtfc_pkg::*;

	// ==========================================================================
	// State
	dtfc_state_e state_reg, state_next;
	dtfc_out_e out_reg, dec_out;
	dtfc_cfg_s cfg_reg;
	dtfc_pwr_e power_reg;
	logic [15:0] stby_cnt_reg;
	logic [7:0] feat_reg, scnt_reg, snum_reg, cyll_reg, cylh_reg, devh_reg, err_reg;
	logic df_reg, errbit_reg, drdy_reg, temp_reg, saved_reg;
	logic ack_reg;
	logic [31:0] rdat_reg;
	logic wr, rd, bsy, drq, cmd_wr, word_wr, last_word, cmd_take;
	logic [7:0] pm_result;

	assign bsy = state_reg == ST_EXEC || state_reg == ST_CHECK;
	assign drq = state_reg == ST_DATA;

	// ==========================================================================
	// Wishbone slave: one wait state, write lands on the ack edge
	assign wr = i_wb.cyc && i_wb.stb && i_wb.we && ack_reg;
	assign rd = i_wb.cyc && i_wb.stb && !i_wb.we && !ack_reg;
	assign o_wb_ack = ack_reg;
	assign o_wb_dat = rdat_reg;

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= i_wb.cyc && i_wb.stb && !ack_reg;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			rdat_reg <= 32'h00000000;
		end else if (rd) begin
			unique case (i_wb.adr)
				`DTFC_OFF_FEAT: rdat_reg <= {24'h000000, err_reg};
				`DTFC_OFF_SCNT: rdat_reg <= {24'h000000, scnt_reg};
				`DTFC_OFF_SNUM: rdat_reg <= {24'h000000, snum_reg};
				`DTFC_OFF_CYLL: rdat_reg <= {24'h000000, cyll_reg};
				`DTFC_OFF_CYLH: rdat_reg <= {24'h000000, cylh_reg};
				`DTFC_OFF_DEVH: rdat_reg <= {24'h000000, devh_reg};
				`DTFC_OFF_CMD: rdat_reg <= {24'h000000, bsy, drdy_reg, df_reg, 1'b0, drq,
					2'b00, errbit_reg};
				`DTFC_OFF_CFG: rdat_reg <= {16'h0000, cfg_reg[15:3], power_reg, cfg_reg.dev_id};
				`DTFC_OFF_STATE: rdat_reg <= {14'h0000, stby_cnt_reg, temp_reg, saved_reg};
				default: rdat_reg <= 32'h00000000;
			endcase
		end
	end

	// ==========================================================================
	// Command decode, sampled when the command code is written
	assign cmd_wr = wr && i_wb.sel[0] && i_wb.adr == `DTFC_OFF_CMD;
	assign word_wr = wr && i_wb.sel[0] && i_wb.adr == `DTFC_OFF_DATA && drq;

	dtfc_cmd_decode u_decode (
		.i_cmd(i_wb.dat[7:0]),
		.i_feat(feat_reg),
		.i_dev_sel(devh_reg[`DTFC_DEV_BIT]),
		.i_cfg(cfg_reg),
		.i_drdy(drdy_reg),
		.i_busy(bsy || drq),
		.i_count_zero({snum_reg, scnt_reg} == 16'h0000),
		.o_out(dec_out)
	);

	dtfc_xfer_count u_count (
		.i_core_clk(i_core_clk),
		.i_rst(i_rst),
		.i_load(state_reg == ST_EXEC && out_reg == OUT_DL_DATA),
		.i_sectors({snum_reg, scnt_reg}),
		.i_word(word_wr),
		.o_last(last_word)
	);

	// Reset and diagnostics cut into a running command; others are taken only when idle
	assign cmd_take = cmd_wr && dec_out != OUT_IGNORE &&
		(state_reg == ST_IDLE || dec_out == OUT_RESET || dec_out == OUT_DIAG);

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			out_reg <= OUT_IGNORE;
		end else if (cmd_take) begin
			out_reg <= dec_out;
		end
	end

	// ==========================================================================
	// Sequencing
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_IDLE: state_next = cmd_take ? ST_EXEC : ST_IDLE;
			ST_EXEC: state_next = (out_reg == OUT_DL_DATA) ? ST_DATA : ST_IDLE;
			ST_DATA: state_next = last_word ? ST_CHECK : ST_DATA;
			ST_CHECK: state_next = ST_IDLE;
		endcase
		if (cmd_take && state_reg != ST_IDLE) begin
			state_next = ST_EXEC;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			state_reg <= ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// ==========================================================================
	// Configuration and power state
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			cfg_reg <= `DTFC_CFG_RST;
		end else if (wr && i_wb.adr == `DTFC_OFF_CFG && i_wb.sel[1:0] == 2'b11) begin
			cfg_reg <= dtfc_cfg_s'(i_wb.dat[15:0]);
		end
	end

	// Only activity other than the query restarts the standby timer
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			power_reg <= PWR_ACTIVE;
			stby_cnt_reg <= 16'h0000;
		end else if (wr && i_wb.adr == `DTFC_OFF_CFG && i_wb.sel[1:0] == 2'b11) begin
			power_reg <= dtfc_pwr_e'(i_wb.dat[2:1]);
			stby_cnt_reg <= 16'h0000;
		end else if (state_reg == ST_EXEC && out_reg != OUT_PM) begin
			stby_cnt_reg <= 16'h0000;
		end else if (power_reg == PWR_IDLE) begin
			if (stby_cnt_reg == 16'(`DTFC_STBY_CYC - 1)) begin
				power_reg <= PWR_STANDBY;
				stby_cnt_reg <= 16'h0000;
			end else begin
				stby_cnt_reg <= stby_cnt_reg + 16'h0001;
			end
		end
	end

	always_comb begin
		unique case (power_reg)
			PWR_STANDBY: pm_result = `DTFC_PM_STANDBY;
			PWR_IDLE: pm_result = `DTFC_PM_IDLE;
			default: pm_result = `DTFC_PM_ACTIVE;
		endcase
	end

	// ==========================================================================
	// Ready flag: software drops it, any completion raises it again
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			drdy_reg <= 1'b1;
		end else if ((state_reg == ST_EXEC && out_reg != OUT_DL_DATA) || state_reg == ST_CHECK) begin
			drdy_reg <= 1'b1;
		end else if (wr && i_wb.adr == `DTFC_OFF_CFG && i_wb.sel[1]) begin
			drdy_reg <= !i_wb.dat[`DTFC_CFG_DROP_READY] && i_wb.dat[2:1] != PWR_SLEEP;
		end
	end

	// ==========================================================================
	// Task-file registers and command results
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			feat_reg <= 8'h00;
			scnt_reg <= 8'h00;
			snum_reg <= 8'h00;
			cyll_reg <= 8'h00;
			cylh_reg <= 8'h00;
			devh_reg <= 8'h00;
		end else if (state_reg == ST_EXEC && (out_reg == OUT_RESET || out_reg == OUT_DIAG)) begin
			scnt_reg <= `DTFC_SIG_SCNT;
			snum_reg <= `DTFC_SIG_SNUM;
			cyll_reg <= `DTFC_SIG_CYLL;
			cylh_reg <= `DTFC_SIG_CYLH;
			devh_reg <= devh_reg & `DTFC_DEVH_DEV;
		end else if (state_reg == ST_EXEC && out_reg == OUT_PM) begin
			scnt_reg <= pm_result;
		end else if (wr && i_wb.sel[0] && state_reg == ST_IDLE) begin
			unique case (i_wb.adr)
				`DTFC_OFF_FEAT: feat_reg <= i_wb.dat[7:0];
				`DTFC_OFF_SCNT: scnt_reg <= i_wb.dat[7:0];
				`DTFC_OFF_SNUM: snum_reg <= i_wb.dat[7:0];
				`DTFC_OFF_CYLL: cyll_reg <= i_wb.dat[7:0];
				`DTFC_OFF_CYLH: cylh_reg <= i_wb.dat[7:0];
				`DTFC_OFF_DEVH: devh_reg <= i_wb.dat[7:0];
				default: feat_reg <= feat_reg;
			endcase
		end
	end

	// Rejected microcode is checked once the last word has landed
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			err_reg <= 8'h00;
			errbit_reg <= 1'b0;
			df_reg <= 1'b0;
		end else if (state_reg == ST_EXEC) begin
			unique case (out_reg)
				OUT_ABORT: begin
					err_reg <= `DTFC_ERR_ABRT;
					errbit_reg <= 1'b1;
					df_reg <= cfg_reg.fault;
				end
				OUT_RESET, OUT_DIAG: begin
					err_reg <= `DTFC_DIAG_PASS;
					errbit_reg <= 1'b0;
					df_reg <= 1'b0;
				end
				OUT_DL_DATA: err_reg <= err_reg;
				default: begin
					err_reg <= 8'h00;
					errbit_reg <= 1'b0;
					df_reg <= 1'b0;
				end
			endcase
		end else if (state_reg == ST_CHECK) begin
			err_reg <= cfg_reg.reject ? `DTFC_ERR_ABRT : 8'h00;
			errbit_reg <= cfg_reg.reject;
			df_reg <= cfg_reg.reject && cfg_reg.fault;
		end
	end

	// Applied microcode: temporary copy is lost on reset, saved copy kept
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			temp_reg <= 1'b0;
			saved_reg <= 1'b0;
		end else if ((state_reg == ST_EXEC && out_reg == OUT_DL_DONE) ||
			(state_reg == ST_CHECK && !cfg_reg.reject)) begin
			temp_reg <= 1'b1;
			saved_reg <= saved_reg || feat_reg == `DTFC_SUB_SAVE;
		end else if (state_reg == ST_EXEC && out_reg == OUT_RESET) begin
			temp_reg <= saved_reg;
		end
	end

	// ==========================================================================
	// Checks
	// Words taken in the data phase; only the checks read this count
	logic [23:0] word_cnt_reg;

	always_ff @(posedge i_core_clk) begin
		if (i_rst || state_reg == ST_EXEC) begin
			word_cnt_reg <= 24'h000000;
		end else if (word_wr) begin
			word_cnt_reg <= word_cnt_reg + 24'h000001;
		end
	end

	a_abort_status: assert property (@(posedge i_core_clk) disable iff (i_rst)
		state_reg == ST_EXEC && out_reg == OUT_ABORT |=>
		!bsy && !drq && drdy_reg && errbit_reg && err_reg == `DTFC_ERR_ABRT)
		else $error("abort left wrong status");
	a_query_power_kept: assert property (@(posedge i_core_clk) disable iff (i_rst)
		state_reg == ST_EXEC && out_reg == OUT_PM && power_reg == PWR_IDLE &&
		stby_cnt_reg < 16'h0384 |=> power_reg == PWR_IDLE &&
		stby_cnt_reg == $past(stby_cnt_reg) + 16'h0001)
		else $error("query disturbed the standby timer");
	a_query_result: assert property (@(posedge i_core_clk) disable iff (i_rst)
		state_reg == ST_EXEC && out_reg == OUT_PM |=>
		scnt_reg == ($past(power_reg) == PWR_STANDBY ? 8'h00 :
		($past(power_reg) == PWR_IDLE ? 8'h80 : 8'hff)))
		else $error("wrong power query result");
	a_pm_status: assert property (@(posedge i_core_clk) disable iff (i_rst)
		state_reg == ST_EXEC && out_reg == OUT_PM |=>
		!bsy && !drq && drdy_reg && !df_reg && !errbit_reg)
		else $error("power query left wrong status");
	a_not_ready_abort: assert property (@(posedge i_core_clk) disable iff (i_rst)
		cmd_wr && state_reg == ST_IDLE && !drdy_reg && devh_reg[4] == cfg_reg.dev_id &&
		(i_wb.dat[7:0] == 8'he5 || i_wb.dat[7:0] == 8'h92) |=> ##1 errbit_reg)
		else $error("command accepted while not ready");
	a_reset_other_dev: assert property (@(posedge i_core_clk) disable iff (i_rst)
		cmd_wr && i_wb.dat[7:0] == 8'h08 && devh_reg[4] != cfg_reg.dev_id |=>
		$stable(state_reg))
		else $error("reset taken by the wrong device");
	a_reset_taken: assert property (@(posedge i_core_clk) disable iff (i_rst)
		cmd_wr && i_wb.dat[7:0] == 8'h08 && cfg_reg.rst_sup &&
		devh_reg[4] == cfg_reg.dev_id |=> state_reg == ST_EXEC ##1 !errbit_reg &&
		err_reg == 8'h01 && devh_reg[3:0] == 4'h0 && !bsy)
		else $error("reset not completed as required");
	a_unsup_reset_abort: assert property (@(posedge i_core_clk) disable iff (i_rst)
		cmd_wr && state_reg == ST_IDLE && i_wb.dat[7:0] == 8'h08 && !cfg_reg.rst_sup &&
		devh_reg[4] == cfg_reg.dev_id |-> ##2 errbit_reg && err_reg == 8'h04 && !bsy)
		else $error("unsupported reset not aborted");
	a_bad_subcommand: assert property (@(posedge i_core_clk) disable iff (i_rst)
		cmd_wr && state_reg == ST_IDLE && i_wb.dat[7:0] == 8'h92 &&
		devh_reg[4] == cfg_reg.dev_id && feat_reg != 8'h01 && feat_reg != 8'h07 |->
		##2 errbit_reg && err_reg == 8'h04 && !bsy && !drq)
		else $error("reserved subcommand not aborted");
	a_whole_sectors: assert property (@(posedge i_core_clk) disable iff (i_rst)
		state_reg == ST_DATA && last_word |-> word_cnt_reg + 24'h000001 ==
		24'({8'h00, snum_reg, scnt_reg} << `DTFC_SECTOR_WORDS_LOG2))
		else $error("data phase length is not whole sectors");
	a_reject_abort: assert property (@(posedge i_core_clk) disable iff (i_rst)
		state_reg == ST_CHECK && cfg_reg.reject |=> !bsy && !drq && drdy_reg &&
		errbit_reg && err_reg == 8'h04 && df_reg == cfg_reg.fault)
		else $error("rejected download left wrong status");
	a_download_ok: assert property (@(posedge i_core_clk) disable iff (i_rst)
		state_reg == ST_CHECK && !cfg_reg.reject |=> !bsy && !drq && drdy_reg &&
		!df_reg && !errbit_reg && err_reg == 8'h00)
		else $error("good download left wrong status");
	a_zero_count: assert property (@(posedge i_core_clk) disable iff (i_rst)
		state_reg == ST_EXEC && out_reg == OUT_DL_DONE |=> state_reg == ST_IDLE &&
		!errbit_reg && !df_reg && temp_reg)
		else $error("zero-count download misbehaved");
	a_diag_runs: assert property (@(posedge i_core_clk) disable iff (i_rst)
		cmd_wr && i_wb.dat[7:0] == 8'h90 |=> state_reg == ST_EXEC ##1
		err_reg == 8'h01 && state_reg == ST_IDLE)
		else $error("diagnostics not run");
endmodule

/* hw/dtfc_defs.svh */
// Offsets, field positions, codes, reset values and timing counts of the task-file block
`ifndef DTFC_DEFS_SVH
`define DTFC_DEFS_SVH
// ==========================================================================
// Register byte offsets on the Wishbone slave
`define DTFC_OFF_DATA 8'h00
`define DTFC_OFF_FEAT 8'h04
`define DTFC_OFF_SCNT 8'h08
`define DTFC_OFF_SNUM 8'h0c
`define DTFC_OFF_CYLL 8'h10
`define DTFC_OFF_CYLH 8'h14
`define DTFC_OFF_DEVH 8'h18
`define DTFC_OFF_CMD 8'h1c
`define DTFC_OFF_CFG 8'h20
`define DTFC_OFF_STATE 8'h24
// ==========================================================================
// Command and subcommand codes
`define DTFC_CMD_PMQ 8'he5
`define DTFC_CMD_RST 8'h08
`define DTFC_CMD_DL 8'h92
`define DTFC_CMD_DIAG 8'h90
`define DTFC_SUB_TEMP 8'h01
`define DTFC_SUB_SAVE 8'h07
// ==========================================================================
// Result values and field positions
`define DTFC_PM_STANDBY 8'h00
`define DTFC_PM_IDLE 8'h80
`define DTFC_PM_ACTIVE 8'hff
`define DTFC_ERR_ABRT 8'h04
`define DTFC_DEVH_DEV 8'h10
`define DTFC_DEV_BIT 4
`define DTFC_DIAG_PASS 8'h01
`define DTFC_SIG_SCNT 8'h01
`define DTFC_SIG_SNUM 8'h01
`define DTFC_SIG_CYLL 8'h00
`define DTFC_SIG_CYLH 8'h00
`define DTFC_CFG_RST 16'h00fc
`define DTFC_CFG_DROP_READY 10
// ==========================================================================
// Transfer and timing
`define DTFC_SECTOR_BYTES 512
`define DTFC_SECTOR_WORDS_LOG2 8
`define DTFC_CLK_MHZ 10
`define DTFC_STBY_TIME_US 100
`define DTFC_STBY_CYC (`DTFC_STBY_TIME_US * `DTFC_CLK_MHZ)
`endif

/* hw/dtfc_pkg.sv */
// Types shared by the task-file command block
package dtfc_pkg;
	// ==========================================================================
	// Control flow
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_EXEC = 4'b0010,
		ST_DATA = 4'b0100,
		ST_CHECK = 4'b1000
	} dtfc_state_e;
	typedef enum logic [2:0] {
		OUT_IGNORE, OUT_ABORT, OUT_PM, OUT_RESET, OUT_DIAG, OUT_DL_DATA, OUT_DL_DONE
	} dtfc_out_e;
	typedef enum logic [1:0] {
		PWR_STANDBY = 2'b00, PWR_IDLE = 2'b01, PWR_ACTIVE = 2'b10, PWR_SLEEP = 2'b11
	} dtfc_pwr_e;
	// ==========================================================================
	// Carriers
	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [3:0] sel;
		logic [7:0] adr;
		logic [31:0] dat;
	} dtfc_wb_req_s;
	typedef struct packed {
		logic [5:0] rsvd;
		logic reject;
		logic fault;
		logic sub_save;
		logic sub_temp;
		logic dl_sup;
		logic rst_sup;
		logic pm_sup;
		logic [1:0] power;
		logic dev_id;
	} dtfc_cfg_s;
endpackage

/* hw/dtfc_cmd_decode.sv */
// Command decode and acceptance check, sampled at the command write
`timescale 1ns/1ps
`include "dtfc_defs.svh"
module dtfc_cmd_decode (
	input wire logic [7:0] i_cmd,
	input wire logic [7:0] i_feat,
	input wire logic i_dev_sel,
	input wire dtfc_pkg::dtfc_cfg_s i_cfg,
	input wire logic i_drdy,
	input wire logic i_busy,
	input wire logic i_count_zero,
	output dtfc_pkg::dtfc_out_e o_out
);
	import dtfc_pkg::*;
	logic sub_ok;

	// ==========================================================================
	// Subcommand support
	assign sub_ok = (i_feat == `DTFC_SUB_TEMP && i_cfg.sub_temp) ||
		(i_feat == `DTFC_SUB_SAVE && i_cfg.sub_save);

	// ==========================================================================
	// Outcome
	always_comb begin
		o_out = OUT_IGNORE;
		if (i_cmd == `DTFC_CMD_DIAG) begin
			o_out = OUT_DIAG;
		end else if (i_dev_sel != i_cfg.dev_id) begin
			o_out = OUT_IGNORE;
		end else if (i_cmd == `DTFC_CMD_RST) begin
			if (i_cfg.rst_sup) begin
				o_out = OUT_RESET;
			end else begin
				// Busy case is undefined; leaving the device alone is safest
				o_out = i_busy ? OUT_IGNORE : OUT_ABORT;
			end
		end else if (i_busy) begin
			o_out = OUT_IGNORE;
		end else if (i_cmd == `DTFC_CMD_PMQ) begin
			o_out = (i_cfg.pm_sup && i_drdy) ? OUT_PM : OUT_ABORT;
		end else if (i_cmd == `DTFC_CMD_DL) begin
			if (!i_cfg.dl_sup || !i_drdy || !sub_ok) begin
				o_out = OUT_ABORT;
			end else begin
				o_out = i_count_zero ? OUT_DL_DONE : OUT_DL_DATA;
			end
		end else begin
			o_out = OUT_ABORT;
		end
	end
endmodule

/* hw/dtfc_xfer_count.sv */
// Word counter for the microcode data phase
`timescale 1ns/1ps
`include "dtfc_defs.svh"
module dtfc_xfer_count (
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic i_load,
	input wire logic [15:0] i_sectors,
	input wire logic i_word,
	output logic o_last
);
	logic [23:0] rem_reg;

	// ==========================================================================
	// Whole sectors only, so the count is loaded in words
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			rem_reg <= 24'h000000;
		end else if (i_load) begin
			rem_reg <= 24'({8'h00, i_sectors} << `DTFC_SECTOR_WORDS_LOG2);
		end else if (i_word && rem_reg != 24'h000000) begin
			rem_reg <= rem_reg - 24'h000001;
		end
	end
	assign o_last = i_word && rem_reg == 24'h000001;
endmodule

/* test/dtfc_host_model.sv */
// Host adapter model driving the task-file block over classic Wishbone
`timescale 1ns/1ps
`include "dtfc_defs.svh"
module dtfc_host_model (
	input wire logic i_core_clk,
	input wire logic i_wb_ack,
	input wire logic [31:0] i_wb_dat,
	output dtfc_pkg::dtfc_wb_req_s o_wb
);
	import dtfc_pkg::*;
	initial o_wb = '0;
	// ==========================================================================
	// Bus cycles
	// Released lines show the inverse, so stale values never pass for valid ones
	task automatic cycle(input logic we, input logic [7:0] adr, input logic [31:0] dat,
		output logic [31:0] rdat);
		@(posedge i_core_clk);
		o_wb <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hf, adr: adr, dat: dat};
		do @(posedge i_core_clk); while (i_wb_ack !== 1'b1);
		rdat = i_wb_dat;
		o_wb <= '{cyc: 1'b0, stb: 1'b0, we: ~we, sel: 4'h0, adr: ~adr, dat: ~dat};
	endtask
	task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
		logic [31:0] unused;
		cycle(1'b1, adr, dat, unused);
	endtask
	task automatic rd(input logic [7:0] adr, output logic [31:0] d);
		cycle(1'b0, adr, 32'h0, d);
	endtask
	// ==========================================================================
	// Command issue
	// Parameters go first, the block samples them at the command write
	task automatic issue(input logic [7:0] feat, input logic [15:0] cnt, input logic [7:0] devh,
		input logic [7:0] code);
		wr(`DTFC_OFF_FEAT, {24'h0, feat});
		wr(`DTFC_OFF_SCNT, {24'h0, cnt[7:0]});
		wr(`DTFC_OFF_SNUM, {24'h0, cnt[15:8]});
		wr(`DTFC_OFF_CYLL, 32'h0);
		wr(`DTFC_OFF_CYLH, 32'h0);
		wr(`DTFC_OFF_DEVH, {24'h0, devh});
		wr(`DTFC_OFF_CMD, {24'h0, code});
	endtask
	// Data words, whole sectors unless a test stops short on purpose
	task automatic send(input int n);
		for (int i = 0; i < n; i++) begin
			wr(`DTFC_OFF_DATA, 32'h5a00 + i);
		end
	endtask
endmodule

/* test/tb_top.sv */
// Self-checking bench for the task-file command block
`timescale 1ns/1ps
`include "dtfc_defs.svh"
module tb_top;
	import dtfc_pkg::*;
	logic i_core_clk;
	logic i_rst;
	dtfc_wb_req_s wb;
	logic ack;
	logic [31:0] rdat;
	logic [31:0] st;
	logic [31:0] v;
	int n_errors;
	int checked;
	localparam int SW = 1 << `DTFC_SECTOR_WORDS_LOG2;
	dtfc_core dut_u (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_wb(wb), .o_wb_ack(ack),
		.o_wb_dat(rdat));
	dtfc_host_model host_u (.i_core_clk(i_core_clk), .i_wb_ack(ack), .i_wb_dat(rdat), .o_wb(wb));
	initial begin
		i_core_clk = 1'b0;
		forever #50 i_core_clk = ~i_core_clk;
	end
	// ==========================================================================
	// Helpers
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rchk(input logic [7:0] adr, input logic [31:0] exp);
		host_u.rd(adr, v);
		chk(v, exp);
	endtask
	// Poll status until not busy; a command that never ends is a mismatch
	task automatic wait_done();
		for (int i = 0; i < 40; i++) begin
			host_u.rd(`DTFC_OFF_CMD, st);
			if (st[7] === 1'b0) return;
		end
		$display("BAD t=%0t got=%h exp=%h", $time, st, 32'h0);
		n_errors++;
		close_out();
	endtask
	task automatic cfg(input logic [15:0] c);
		host_u.wr(`DTFC_OFF_CFG, {16'h0, c});
	endtask
	task automatic run(input logic [7:0] feat, input logic [15:0] cnt, input logic [7:0] code);
		host_u.issue(feat, cnt, 8'h00, code);
		wait_done();
	endtask
	// ==========================================================================
	// Scenarios
	task automatic t_regs();
		rchk(`DTFC_OFF_CMD, 32'h40);
		rchk(`DTFC_OFF_CFG, {16'h0, `DTFC_CFG_RST});
		rchk(`DTFC_OFF_SCNT, 32'h0);
		host_u.wr(8'h40, 32'h55);
		rchk(8'h40, 32'h0);
		$display("test regs done");
	endtask
	task automatic t_pmq();
		logic [7:0] res [3];
		res = '{`DTFC_PM_STANDBY, `DTFC_PM_IDLE, `DTFC_PM_ACTIVE};
		for (int p = 0; p < 4; p++) begin
			cfg(16'h00f8 | 16'(p << 1));
			run(8'h00, 16'h0, `DTFC_CMD_PMQ);
			if (p < 3) begin
				chk(st, 32'h40);
				rchk(`DTFC_OFF_SCNT, {24'h0, res[p]});
			end else begin
				rchk(`DTFC_OFF_FEAT, {24'h0, `DTFC_ERR_ABRT});
			end
			rchk(`DTFC_OFF_CFG, 32'h00f8 | 32'(p << 1));
		end
		cfg(`DTFC_CFG_RST);
		$display("test pmq done");
	endtask
	task automatic t_abort();
		cfg(16'h00f4);
		run(8'h00, 16'h0, `DTFC_CMD_PMQ);
		chk(st, 32'h41);
		rchk(`DTFC_OFF_FEAT, {24'h0, `DTFC_ERR_ABRT});
		cfg(16'h04fc);
		run(8'h00, 16'h0, `DTFC_CMD_RST);
		rchk(`DTFC_OFF_FEAT, {24'h0, `DTFC_DIAG_PASS});
		// Completing the reset raised ready again
		cfg(16'h04fc);
		run(`DTFC_SUB_TEMP, 16'h0, `DTFC_CMD_DL);
		chk({31'h0, st[0]}, 32'h1);
		rchk(`DTFC_OFF_FEAT, {24'h0, `DTFC_ERR_ABRT});
		cfg(`DTFC_CFG_RST);
		$display("test abort done");
	endtask
	task automatic t_reset();
		host_u.wr(`DTFC_OFF_CYLL, 32'h33);
		host_u.wr(`DTFC_OFF_DEVH, 32'h1f);
		host_u.wr(`DTFC_OFF_CMD, {24'h0, `DTFC_CMD_RST});
		wait_done();
		rchk(`DTFC_OFF_CYLL, 32'h33);
		host_u.wr(`DTFC_OFF_DEVH, 32'h0f);
		host_u.wr(`DTFC_OFF_CMD, {24'h0, `DTFC_CMD_RST});
		wait_done();
		chk({31'h0, st[0]}, 32'h0);
		rchk(`DTFC_OFF_FEAT, {24'h0, `DTFC_DIAG_PASS});
		rchk(`DTFC_OFF_SCNT, {24'h0, `DTFC_SIG_SCNT});
		rchk(`DTFC_OFF_SNUM, {24'h0, `DTFC_SIG_SNUM});
		rchk(`DTFC_OFF_CYLL, {24'h0, `DTFC_SIG_CYLL});
		rchk(`DTFC_OFF_CYLH, {24'h0, `DTFC_SIG_CYLH});
		rchk(`DTFC_OFF_DEVH, 32'h0);
		run(`DTFC_SUB_TEMP, 16'h0001, `DTFC_CMD_DL);
		chk(st, 32'h48);
		host_u.wr(`DTFC_OFF_CMD, {24'h0, `DTFC_CMD_RST});
		wait_done();
		chk(st & 32'h89, 32'h0);
		cfg(16'h00ec);
		run(8'h00, 16'h0, `DTFC_CMD_RST);
		chk(st, 32'h41);
		rchk(`DTFC_OFF_FEAT, {24'h0, `DTFC_ERR_ABRT});
		cfg(`DTFC_CFG_RST);
		$display("test reset done");
	endtask
	task automatic t_download();
		logic [7:0] subs [2];
		subs = '{`DTFC_SUB_TEMP, `DTFC_SUB_SAVE};
		run(`DTFC_SUB_SAVE, 16'h0100, `DTFC_CMD_DL);
		// Error flag still mirrors the abort code left by the last test
		chk(st, 32'h49);
		run(8'h00, 16'h0, `DTFC_CMD_RST);
		run(`DTFC_SUB_TEMP, 16'h0, `DTFC_CMD_DL);
		chk(st, 32'h40);
		for (int s = 0; s < 2; s++) begin
			// Reset first, so only this download can raise the flag looked at below
			run(8'h00, 16'h0, `DTFC_CMD_RST);
			run(subs[s], 16'h0001, `DTFC_CMD_DL);
			chk(st, 32'h48);
			host_u.send(SW - 1);
			rchk(`DTFC_OFF_CMD, 32'h48);
			host_u.send(1);
			wait_done();
			chk(st, 32'h40);
			host_u.rd(`DTFC_OFF_STATE, v);
			chk({31'h0, v[1 - s]}, 32'h1);
		end
		cfg(16'h01fc);
		run(8'h03, 16'h0001, `DTFC_CMD_DL);
		chk(st, 32'h61);
		cfg(16'h02fc);
		run(`DTFC_SUB_TEMP, 16'h0001, `DTFC_CMD_DL);
		host_u.send(SW);
		wait_done();
		chk(st, 32'h41);
		cfg(16'h00dc);
		run(`DTFC_SUB_TEMP, 16'h0, `DTFC_CMD_DL);
		chk(st, 32'h41);
		cfg(`DTFC_CFG_RST);
		$display("test download done");
	endtask
	task automatic t_diag();
		cfg(16'h04fc);
		host_u.wr(`DTFC_OFF_DEVH, {24'h0, `DTFC_DEVH_DEV});
		host_u.wr(`DTFC_OFF_CMD, {24'h0, `DTFC_CMD_DIAG});
		wait_done();
		chk({31'h0, st[7]}, 32'h0);
		rchk(`DTFC_OFF_FEAT, {24'h0, `DTFC_DIAG_PASS});
		cfg(`DTFC_CFG_RST);
		$display("test diag done");
	endtask
	// ==========================================================================
	// Verdict
	task automatic close_out();
		$display("errors=%0d checks=%0d", n_errors, checked);
		if (n_errors == 0 && checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	initial begin
		repeat (60000) @(posedge i_core_clk);
		n_errors++;
		close_out();
	end
	initial begin
		n_errors = 0;
		checked = 0;
		i_rst = 1'b1;
		repeat (8) @(posedge i_core_clk);
		i_rst <= 1'b0;
		t_regs();
		t_pmq();
		t_abort();
		t_reset();
		t_download();
		t_diag();
		close_out();
	end
endmodule
